// ===== logic/imu_consts.svh
// Field positions, opcodes and timing counts of the integer multiply unit.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IMU_CONSTS_SVH
`define IMU_CONSTS_SVH

`define IMU_DATA_W      32
`define IMU_IDX_W       5
`define IMU_OPC_W       6
`define IMU_IMM_W       16

// Instruction word fields
`define IMU_A_HI        31
`define IMU_A_LO        27
`define IMU_B_HI        26
`define IMU_B_LO        22
`define IMU_C_HI        21
`define IMU_C_LO        17
`define IMU_OPX_HI      16
`define IMU_OPX_LO      11
`define IMU_SH_HI       10
`define IMU_SH_LO       6
`define IMU_IMM_HI      21
`define IMU_IMM_LO      6
`define IMU_IMM_SIGN    15
`define IMU_OP_HI       5
`define IMU_OP_LO       0

// Primary opcodes
`define IMU_OPC_MULI    6'h24
`define IMU_OPC_RTYPE   6'h3A

// Extended opcodes of the register form
`define IMU_OPX_MUL     6'h27
`define IMU_OPX_MULXUU  6'h07
`define IMU_SH_ZERO     5'h00

// Cycles from an accepted instruction to its answer
`define IMU_LATENCY     2

`endif

// ===== logic/imu_pkg.sv
// Types shared by the integer multiply unit.
// Assumes imu_consts.svh sits on the include path.
`include "imu_consts.svh"

package imu_pkg;

  // Multiply operations the unit recognises
  typedef enum logic [1:0] {
    IMU_OP_NONE,
    IMU_OP_MUL,
    IMU_OP_MULI,
    IMU_OP_MULXUU
  } imu_op_t;

endpackage : imu_pkg

// ===== logic/imu_mult.sv
// Registered unsigned multiplier of the integer multiply unit.
// Assumes operands are stable in the cycle that start is high.
`include "imu_consts.svh"

module imu_mult #(
  parameter int WIDTH = `IMU_DATA_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic [WIDTH-1:0]     op_a,
  input  wire logic [WIDTH-1:0]     op_b,
  output logic      [2*WIDTH-1:0]   prod_r,
  output logic                      done_r
);
  import imu_pkg::*;

  logic [2*WIDTH-1:0] prod_nxt;
  logic               done_nxt;

  // Full unsigned product; low half is sign-agnostic, so one array serves both
  always_comb begin
    prod_nxt = prod_r;
    done_nxt = start;
    if (start) begin
      prod_nxt = (2*WIDTH)'(op_a) * (2*WIDTH)'(op_b);
    end
  end

  // Product register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prod_r <= '0;
      done_r <= 1'b0;
    end else begin
      prod_r <= prod_nxt;
      done_r <= done_nxt;
    end
  end

endmodule : imu_mult

// ===== logic/imu_top.sv
// Integer multiply unit: decodes and executes the register-form and
// immediate-form multiplies, plus the unsigned extended upper-half multiply.
// Assumes the register file presents the values of fields A and B in the
// same cycle as instr_valid, and writes back on res_we_r.
`include "imu_consts.svh"

module imu_top #(
  parameter bit               HAS_MUL    = 1'b1,
  parameter bit               HAS_MULI   = 1'b1,
  parameter bit               HAS_MULXUU = 1'b1,
  parameter logic [5:0]       OPX_MUL    = `IMU_OPX_MUL,
  parameter logic [5:0]       OPX_MULXUU = `IMU_OPX_MULXUU
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       instr_valid,
  input  wire logic [`IMU_DATA_W-1:0]     instr_word,
  input  wire logic [`IMU_DATA_W-1:0]     source_reg_a,
  input  wire logic [`IMU_DATA_W-1:0]     source_or_dest_reg_b,
  output logic                            res_valid_r,
  output logic                            res_we_r,
  output logic      [`IMU_IDX_W-1:0]      res_dest_r,
  output logic      [`IMU_DATA_W-1:0]     res_data_r,
  output imu_pkg::imu_op_t                res_op_r,
  output logic                            unimpl_exc_r
);
  import imu_pkg::*;

  // Classify an instruction word; also used by the checks below
  function automatic imu_op_t decode_op(input logic [`IMU_DATA_W-1:0] w);
    logic [`IMU_OPC_W-1:0] opc;
    logic [`IMU_OPC_W-1:0] opx;
    logic [`IMU_IDX_W-1:0] sh;
    opc = w[`IMU_OP_HI:`IMU_OP_LO];
    opx = w[`IMU_OPX_HI:`IMU_OPX_LO];
    sh  = w[`IMU_SH_HI:`IMU_SH_LO];
    decode_op = IMU_OP_NONE;
    if (opc == `IMU_OPC_MULI) begin
      decode_op = IMU_OP_MULI;
    end else if (opc == `IMU_OPC_RTYPE && sh == `IMU_SH_ZERO) begin
      if (opx == OPX_MUL) begin
        decode_op = IMU_OP_MUL;
      end else if (opx == OPX_MULXUU) begin
        decode_op = IMU_OP_MULXUU;
      end
    end
  endfunction : decode_op

  // Sign-extend the immediate field of an I-type word
  function automatic logic [`IMU_DATA_W-1:0] sext_imm(input logic [`IMU_DATA_W-1:0] w);
    logic [`IMU_IMM_W-1:0] imm;
    imm = w[`IMU_IMM_HI:`IMU_IMM_LO];
    sext_imm = {{(`IMU_DATA_W-`IMU_IMM_W){imm[`IMU_IMM_SIGN]}}, imm};
  endfunction : sext_imm

  // Is the hardware for this operation built?
  function automatic logic op_built(input imu_op_t op);
    case (op)
      IMU_OP_MUL:    op_built = HAS_MUL;
      IMU_OP_MULI:   op_built = HAS_MULI;
      IMU_OP_MULXUU: op_built = HAS_MULXUU;
      default:       op_built = 1'b0;
    endcase
  endfunction : op_built

  // Decode stage signals
  imu_op_t                 dec_op;
  logic                    dec_hit;
  logic                    dec_trap;
  logic [`IMU_IDX_W-1:0]   dec_dest;
  logic [`IMU_DATA_W-1:0]  mul_b;
  logic                    mul_start;

  // Operand and destination selection for the decoded instruction
  always_comb begin
    dec_op    = decode_op(instr_word);
    dec_hit   = instr_valid && (dec_op != IMU_OP_NONE);
    dec_trap  = dec_hit && !op_built(dec_op);
    mul_start = dec_hit && !dec_trap; // Trapped words leave the array idle
    if (dec_op == IMU_OP_MULI) begin
      mul_b    = sext_imm(instr_word);
      dec_dest = instr_word[`IMU_B_HI:`IMU_B_LO];
    end else begin
      mul_b    = source_or_dest_reg_b;
      dec_dest = instr_word[`IMU_C_HI:`IMU_C_LO];
    end
  end

  // Multiplier array, one registered stage
  logic [2*`IMU_DATA_W-1:0] prod_r;
  logic                     prod_done_r;

  imu_mult #(
    .WIDTH (`IMU_DATA_W)
  ) u_mult (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (mul_start),
    .op_a     (source_reg_a),
    .op_b     (mul_b),
    .prod_r   (prod_r),
    .done_r   (prod_done_r)
  );

  // Stage-one bookkeeping travelling beside the product
  imu_op_t                s1_op_r,    s1_op_nxt;
  logic                   s1_valid_r, s1_valid_nxt;
  logic                   s1_trap_r,  s1_trap_nxt;
  logic [`IMU_IDX_W-1:0]  s1_dest_r,  s1_dest_nxt;

  always_comb begin
    s1_valid_nxt = dec_hit;
    s1_trap_nxt  = dec_trap;
    s1_op_nxt    = dec_hit ? dec_op : IMU_OP_NONE;
    s1_dest_nxt  = dec_hit ? dec_dest : s1_dest_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_valid_r <= 1'b0;
      s1_trap_r  <= 1'b0;
      s1_op_r    <= IMU_OP_NONE;
      s1_dest_r  <= '0;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      s1_trap_r  <= s1_trap_nxt;
      s1_op_r    <= s1_op_nxt;
      s1_dest_r  <= s1_dest_nxt;
    end
  end

  // Result stage next values
  logic                    res_valid_nxt;
  logic                    res_we_nxt;
  logic [`IMU_IDX_W-1:0]   res_dest_nxt;
  logic [`IMU_DATA_W-1:0]  res_data_nxt;
  imu_op_t                 res_op_nxt;
  logic                    unimpl_exc_nxt;

  // Pick the half of the product; a trap never asserts the write strobe
  always_comb begin
    res_valid_nxt  = s1_valid_r;
    res_we_nxt     = s1_valid_r && !s1_trap_r && prod_done_r;
    unimpl_exc_nxt = s1_valid_r && s1_trap_r;
    res_op_nxt     = s1_op_r;
    res_dest_nxt   = s1_valid_r ? s1_dest_r : res_dest_r;
    res_data_nxt   = res_data_r; // Held, so a trap leaves the last written result in place
    if (res_we_nxt) begin
      if (s1_op_r == IMU_OP_MULXUU) begin
        res_data_nxt = prod_r[2*`IMU_DATA_W-1:`IMU_DATA_W];
      end else begin
        res_data_nxt = prod_r[`IMU_DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_valid_r  <= 1'b0;
      res_we_r     <= 1'b0;
      res_dest_r   <= '0;
      res_data_r   <= '0;
      res_op_r     <= IMU_OP_NONE;
      unimpl_exc_r <= 1'b0;
    end else begin
      res_valid_r  <= res_valid_nxt;
      res_we_r     <= res_we_nxt;
      res_dest_r   <= res_dest_nxt;
      res_data_r   <= res_data_nxt;
      res_op_r     <= res_op_nxt;
      unimpl_exc_r <= unimpl_exc_nxt;
    end
  end

  // Reference values for the checks, computed independently of the array
  logic [2*`IMU_DATA_W-1:0] chk_uu;
  logic [2*`IMU_DATA_W-1:0] chk_ss;
  logic [2*`IMU_DATA_W-1:0] chk_imm;
  logic                     chk_mul;
  logic                     chk_muli;
  logic                     chk_xuu;

  always_comb begin
    chk_uu   = (2*`IMU_DATA_W)'(source_reg_a) * (2*`IMU_DATA_W)'(source_or_dest_reg_b);
    chk_ss   = (2*`IMU_DATA_W)'($signed(source_reg_a) * $signed(source_or_dest_reg_b));
    chk_imm  = (2*`IMU_DATA_W)'($signed(source_reg_a) *
               $signed({{(`IMU_DATA_W-`IMU_IMM_W){instr_word[`IMU_IMM_HI]}},
                        instr_word[`IMU_IMM_HI:`IMU_IMM_LO]}));
    chk_mul  = instr_valid && decode_op(instr_word) == IMU_OP_MUL;
    chk_muli = instr_valid && decode_op(instr_word) == IMU_OP_MULI;
    chk_xuu  = instr_valid && decode_op(instr_word) == IMU_OP_MULXUU;
  end

  a_mul_low_half: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_mul && HAS_MUL) |-> ##2
      (res_we_r && res_data_r == $past(chk_uu[`IMU_DATA_W-1:0], 2)))
    else $error("register multiply low half wrong");

  a_mul_sign_free: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_mul && HAS_MUL) |-> ##2 (res_data_r == $past(chk_ss[`IMU_DATA_W-1:0], 2)))
    else $error("register multiply differs from signed product");

  a_mul_trap: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_mul && !HAS_MUL) |-> ##2 (unimpl_exc_r && res_valid_r))
    else $error("missing multiply did not trap");

  a_muli_product: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_muli && HAS_MULI) |-> ##2
      (res_we_r && res_data_r == $past(chk_imm[`IMU_DATA_W-1:0], 2)))
    else $error("immediate multiply used wrong extension");

  a_muli_dest: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_muli && HAS_MULI) |-> ##2
      (res_dest_r == $past(instr_word[`IMU_B_HI:`IMU_B_LO], 2) && res_op_r == IMU_OP_MULI))
    else $error("immediate multiply wrote wrong register");

  a_muli_unsigned: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_muli && HAS_MULI) |-> ##2 (res_data_r == $past(source_reg_a, 2) *
      $past({{(`IMU_DATA_W-`IMU_IMM_W){instr_word[`IMU_IMM_HI]}},
             instr_word[`IMU_IMM_HI:`IMU_IMM_LO]}, 2)))
    else $error("immediate multiply depends on signedness");

  a_muli_trap: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_muli && !HAS_MULI) |-> ##1 !res_we_r ##1 (unimpl_exc_r && !res_we_r))
    else $error("missing immediate multiply did not trap");

  a_opcode_seen: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(res_valid_r) |-> ($past(instr_word[`IMU_OP_HI:`IMU_OP_LO], 2) == `IMU_OPC_MULI ||
                            $past(instr_word[`IMU_OP_HI:`IMU_OP_LO], 2) == `IMU_OPC_RTYPE))
    else $error("answer without a multiply opcode");

  a_rtype_dest: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_mul || chk_xuu) |-> ##2 (res_dest_r == $past(instr_word[`IMU_C_HI:`IMU_C_LO], 2)))
    else $error("register form wrote wrong register");

  a_carry_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    (chk_xuu && HAS_MULXUU) |-> ##2
      (res_we_r && ((res_data_r != '0) == $past(chk_uu[2*`IMU_DATA_W-1:`IMU_DATA_W] != '0, 2))))
    else $error("upper half does not flag carry");

  a_trap_no_write: assert property (
    @(posedge core_clk) disable iff (rst)
    unimpl_exc_r |-> (!res_we_r && res_valid_r && $stable(res_data_r)))
    else $error("trapped multiply wrote a result");

endmodule : imu_top

// ===== tb/imu_regfile_model.sv
// Register file model facing the multiply unit: operand reads and write-back.
// Assumes the bench preloads registers before issuing words.
`include "imu_consts.svh"

module imu_regfile_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] instr_word,
  input  wire logic        we,
  input  wire logic [4:0]  dest,
  input  wire logic [31:0] data,
  output logic      [31:0] val_a,
  output logic      [31:0] val_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] regs [0:31];

  // Same-cycle reads; the unit samples operands with the word
  assign val_a = regs[instr_word[`IMU_A_HI:`IMU_A_LO]];
  assign val_b = regs[instr_word[`IMU_B_HI:`IMU_B_LO]];

  // Write-back only on the unit's write pulse
  always @(posedge core_clk) begin
    if (we) begin
      regs[dest] <= data;
    end
  end
endmodule : imu_regfile_model

// ===== tb/testbench.sv
// Self-checking bench: full unit and a build with no multiply hardware side by side.
// Assumes answers come one edge after the taking edge, two after the presenting edge.
`include "imu_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import imu_pkg::*;

  typedef struct {
    logic [31:0] w, va, vb, ed;
    logic        ev;
    logic [4:0]  edst;
    imu_op_t     eo;
  } imu_row_t;

  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  logic        instr_valid = 1'b0;
  logic [31:0] instr_word  = 32'h0;
  logic [31:0] val_a, val_b, q1, q2;
  logic        v1, we1, ex1, v2, we2, ex2;
  logic [4:0]  d1, d2;
  imu_op_t     o1, o2;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic        due = 1'b0;
  int          dueq [$];
  imu_row_t    rows [9];
  imu_row_t    exq [$];
  imu_row_t    cur, e;

  always #2 core_clk = ~core_clk;

  imu_top imu_top_inst (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .source_reg_a(val_a), .source_or_dest_reg_b(val_b),
    .res_valid_r(v1), .res_we_r(we1), .res_dest_r(d1), .res_data_r(q1), .res_op_r(o1),
    .unimpl_exc_r(ex1));
  // Build without any multiplier: every multiply must trap
  imu_top #(.HAS_MUL(1'b0), .HAS_MULI(1'b0), .HAS_MULXUU(1'b0)) imu_top_nohw_inst (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .source_reg_a(val_a), .source_or_dest_reg_b(val_b),
    .res_valid_r(v2), .res_we_r(we2), .res_dest_r(d2), .res_data_r(q2), .res_op_r(o2),
    .unimpl_exc_r(ex2));
  imu_regfile_model imu_regfile_model_inst (.core_clk(core_clk), .instr_word(instr_word),
    .we(we1), .dest(d1), .data(q1), .val_a(val_a), .val_b(val_b));

  task automatic cmp_w(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask : cmp_w

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] mkr(input logic [4:0] a, b, c, input logic [5:0] x,
                                      input logic [4:0] sh);
    return {a, b, c, x, sh, `IMU_OPC_RTYPE};
  endfunction : mkr

  function automatic logic [31:0] mki(input logic [4:0] a, b, input logic [15:0] imm,
                                      input logic [5:0] opc);
    return {a, b, imm, opc};
  endfunction : mki

  // Cycle count and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Mid-cycle monitor, after the edge's updates have landed
  always @(negedge core_clk) begin
    if (!rst && instr_valid && cur.ev) begin
      exq.push_back(cur);
      dueq.push_back(cyc + 2);
    end
    // Answer stands in the cycle after the second edge from the presenting edge
    due = dueq.size() != 0 && dueq[0] == cyc;
    cmp_w("trap build valid", {31'h0, v1}, {31'h0, v2});
    if (v1 !== 1'b0 || due) begin
      cmp_w("res_valid_r", {31'h0, due}, {31'h0, v1});
      if (due) begin
        e = exq.pop_front();
        void'(dueq.pop_front());
        cmp_w("res_data_r", e.ed, q1);
        cmp_w("res_dest_r", {27'h0, e.edst}, {27'h0, d1});
        cmp_w("res_op_r", {30'h0, e.eo}, {30'h0, o1});
        cmp_w("res_we_r", 32'h1, {31'h0, we1});
        cmp_w("exception full", 32'h0, {31'h0, ex1});
        cmp_w("exception bare", 32'h1, {31'h0, ex2});
        cmp_w("write bare", 32'h0, {31'h0, we2});
        cmp_w("data bare", 32'h0, q2);
        cmp_w("dest bare", {27'h0, e.edst}, {27'h0, d2});
        cmp_w("op bare", {30'h0, e.eo}, {30'h0, o2});
      end
    end
  end

  initial begin
    rows[0] = '{mkr(5'h01, 5'h02, 5'h14, `IMU_OPX_MUL, 5'h00), 32'h0000_1234,
                32'h0000_0010, 32'h0001_2340, 1'b1, 5'h14, IMU_OP_MUL};
    rows[1] = '{mkr(5'h03, 5'h04, 5'h15, `IMU_OPX_MUL, 5'h00), 32'hFFFF_FFFF,
                32'h0000_0002, 32'hFFFF_FFFE, 1'b1, 5'h15, IMU_OP_MUL};
    rows[2] = '{mki(5'h07, 5'h08, 16'hFF9C, `IMU_OPC_MULI), 32'h0000_000A,
                32'h0, 32'hFFFF_FC18, 1'b1, 5'h08, IMU_OP_MULI};
    rows[3] = '{mki(5'h09, 5'h10, 16'h7FFF, `IMU_OPC_MULI), 32'hFFFF_FFFF,
                32'h0, 32'hFFFF_8001, 1'b1, 5'h10, IMU_OP_MULI};
    rows[4] = '{mkr(5'h0A, 5'h0B, 5'h17, `IMU_OPX_MULXUU, 5'h00), 32'hFFFF_FFFF,
                32'hFFFF_FFFF, 32'hFFFF_FFFE, 1'b1, 5'h17, IMU_OP_MULXUU};
    rows[5] = '{mkr(5'h0C, 5'h0D, 5'h18, `IMU_OPX_MULXUU, 5'h00), 32'h0000_FFFF,
                32'h0001_0001, 32'h0, 1'b1, 5'h18, IMU_OP_MULXUU};
    rows[6] = '{mki(5'h01, 5'h02, 16'h0005, 6'h04), 32'h0, 32'h0, 32'h0, 1'b0, 5'h00,
                IMU_OP_NONE};
    rows[7] = '{mkr(5'h01, 5'h02, 5'h19, `IMU_OPX_MUL, 5'h01), 32'h0, 32'h0, 32'h0,
                1'b0, 5'h00, IMU_OP_NONE};
    rows[8] = '{mkr(5'h0E, 5'h0F, 5'h19, `IMU_OPX_MULXUU, 5'h00), 32'h0001_0000,
                32'h0001_0000, 32'h0000_0001, 1'b1, 5'h19, IMU_OP_MULXUU};
    cur = rows[6];
    for (int i = 0; i < 32; i++) imu_regfile_model_inst.regs[i] = 32'h0;
    foreach (rows[i]) if (rows[i].ev) begin
      imu_regfile_model_inst.regs[rows[i].w[31:27]] = rows[i].va;
      imu_regfile_model_inst.regs[rows[i].w[26:22]] = rows[i].vb;
    end
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    cmp_w("reset data", 32'h0, q1);
    cmp_w("reset op", {30'h0, IMU_OP_NONE}, {30'h0, o1});
    @(posedge core_clk);
    rst <= 1'b0;
    // Back-to-back words, one per cycle, including refused ones
    foreach (rows[i]) begin
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_word  <= rows[i].w;
      cur = rows[i];
    end
    // Reset lands while a word is in flight: its answer must never appear
    @(posedge core_clk);
    instr_word <= rows[0].w;
    cur = rows[6];
    @(posedge core_clk);
    instr_valid <= 1'b0;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    cmp_w("data after reset", 32'h0, q1);
    // Most negative immediate right after reset release
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word  <= mki(5'h01, 5'h11, 16'h8000, `IMU_OPC_MULI);
    cur = '{32'h0, 32'h0, 32'h0, 32'hF6E6_0000, 1'b1, 5'h11, IMU_OP_MULI};
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (5) @(posedge core_clk);
    cmp_w("answers left", 32'h0, exq.size());
    report_and_stop();
  end
endmodule : testbench
